// >>> common/pbs_pkg.sv
// Package for the page buffer operations and status read block.
// Assumes a 25 MHz core clock and a serial host in clock mode 0 or 3.
package pbs_pkg;

  // Command opcodes.
  localparam logic [7:0] OP_XFER_B1    = 8'h53;
  localparam logic [7:0] OP_XFER_B2    = 8'h55;
  localparam logic [7:0] OP_COMP_B1    = 8'h60;
  localparam logic [7:0] OP_COMP_B2    = 8'h61;
  localparam logic [7:0] OP_REWRITE_B1 = 8'h58;
  localparam logic [7:0] OP_REWRITE_B2 = 8'h59;
  localparam logic [7:0] OP_STATUS     = 8'hD7;

  // Serial framing.
  localparam int          OPC_BITS     = 8;
  localparam int          ADDR_BITS    = 24;
  localparam logic [4:0]  OPC_LAST     = 5'h07;
  localparam logic [4:0]  ADDR_LAST    = 5'h17;

  // Page field inside the three address bytes.
  localparam int          PAGE_W       = 12;
  localparam int          PG528_LSB    = 10;
  localparam int          PG512_LSB    = 9;

  // Status byte one field positions.
  localparam int          ST_RDY_BIT   = 7;
  localparam int          ST_CMP_BIT   = 6;
  localparam int          ST_CAP_MSB   = 5;
  localparam int          ST_CAP_LSB   = 2;
  localparam int          ST_GUARD_BIT = 1;
  localparam int          ST_PGSZ_BIT  = 0;

  // Capacity code; this value is arbitrary.
  localparam logic [3:0]  CAP_CODE     = 4'h5;

  // Reset values.
  localparam logic [3:0]  STAT_IDX_RST = 4'h0;
  localparam logic [7:0]  BYTE_RST     = 8'h00;

  typedef enum logic [1:0] {
    PH_CMD,
    PH_ADDR,
    PH_STATUS,
    PH_IGNORE
  } pbs_phase_e;

  typedef enum logic [2:0] {
    SQ_IDLE,
    SQ_XFER,
    SQ_COMP,
    SQ_RW_XFER,
    SQ_RW_PROG
  } pbs_seq_e;

  typedef enum logic [1:0] {
    AOP_XFER,
    AOP_COMPARE,
    AOP_PROGRAM
  } pbs_aop_e;

  // Request to the memory array and buffer engine.
  typedef struct packed {
    pbs_aop_e                op;
    logic                    buf_sel;
    logic [PAGE_W-1:0]       page;
  } pbs_arr_req_s;

  // Serial pins after synchronisation.
  typedef struct packed {
    logic cs_b;
    logic sck;
    logic si;
  } pbs_pins_s;

endpackage

// >>> src/pbs_sync.sv
// Two flip-flop synchroniser for a group of level signals.
// Assumes the inputs are asynchronous to mclk_i.
`timescale 1ns/10ps
module pbs_sync #(
  parameter int          W   = 1,
  parameter logic [W-1:0] RST = '0
) (
  // Clock and reset
  input  wire logic         mclk_i,
  input  wire logic         rst_b_i,
  // Data
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);

  logic [W-1:0] meta_reg;
  logic [W-1:0] q_reg;

  always_ff @(posedge mclk_i)
  begin
    if (!rst_b_i)
    begin
      meta_reg <= RST;
      q_reg    <= RST;
    end
    else
    begin
      meta_reg <= d_i;
      q_reg    <= meta_reg;
    end
  end

  assign q_o = q_reg;

endmodule

// >>> src/pbs_core.sv
// Command decoder, page operation sequencer and status read shifter.
// Assumes the serial pins are asynchronous and slow against mclk_i, and an
// array engine on mclk_i that answers each request with one done pulse.
//
// Overview of operation
// - 53h or 55h plus address copies page
// - 528 mode: 2 skip, 12 page, 10 skip
// - 512 mode: 3 skip, 12 page, 9 skip
// - Operation launches on chip select rising
// - Busy during copy, ready when done
// - 60h or 61h plus address compares page
// - Compare busy, result lands in bit 6
// - Mismatch flag 0 equal, 1 differs
// - 58h or 59h plus address rewrites page
// - Rewrite copies then programs, busy throughout
// - D7h starts status output every clock
// - Status wraps after second byte
// - Ready flag resampled for every byte
// - Status read accepted even while busy
// - Chip select high ends read, releases output
// - Byte one bit 7 is ready flag
// - Byte one bits 5:2 capacity code
// - Byte one bit 1 sector guard
// - Byte one bit 0 page length select
`timescale 1ns/10ps
module pbs_core (
  // Clock and reset
  input  wire logic                 mclk_i,
  input  wire logic                 rst_b_i,
  // Serial pins
  input  wire logic                 cs_b_i,
  input  wire logic                 sck_i,
  input  wire logic                 si_i,
  output logic                      so_o,
  output logic                      so_oe_o,
  // Configuration
  input  wire logic                 sector_guard_i,
  input  wire logic                 page_len_528_i,
  // Array engine
  output logic                      arr_req_vld_o,
  output pbs_pkg::pbs_arr_req_s     arr_req_o,
  input  wire logic                 arr_done_i,
  input  wire logic                 arr_mismatch_i,
  // Status
  output logic                      ready_o
);

  typedef struct packed {
    logic                  sck_prev;
    logic                  cs_prev;
    pbs_pkg::pbs_phase_e   phase;
    logic [4:0]            bit_cnt;
    logic [7:0]            opcode;
    logic [23:0]           addr;
    logic                  armed;
    pbs_pkg::pbs_seq_e     seq;
    logic                  mismatch;
    logic [3:0]            stat_idx;
    logic [7:0]            stat_byte;
    logic                  so;
    logic                  so_oe;
    logic                  rdy;
    logic                  req_vld;
    pbs_pkg::pbs_arr_req_s req;
  } pbs_state_s;

  pbs_pkg::pbs_pins_s pins_q;
  pbs_state_s         st_reg;
  pbs_state_s         st_next;
  logic               sck_rise;
  logic               sck_fall;
  logic               cs_rise;
  logic [7:0]         opc_full;
  logic [23:0]        addr_full;
  logic [7:0]         byte_one;
  logic [7:0]         byte_two;
  logic [7:0]         fresh_byte;
  logic [11:0]        page_sel;

  pbs_sync #(
    .W   (3),
    .RST (3'h4)
  ) u_pin_sync (
    .mclk_i  (mclk_i),
    .rst_b_i (rst_b_i),
    .d_i     ({cs_b_i, sck_i, si_i}),
    .q_o     (pins_q)
  );

  assign sck_rise  = pins_q.sck && !st_reg.sck_prev;
  assign sck_fall  = !pins_q.sck && st_reg.sck_prev;
  assign cs_rise   = pins_q.cs_b && !st_reg.cs_prev;
  assign opc_full  = {st_reg.opcode[6:0], pins_q.si};
  assign addr_full = {st_reg.addr[22:0], pins_q.si};

  // Status byte one carries live state; byte two holds only the ready flag.
  always_comb
  begin
    byte_one = pbs_pkg::BYTE_RST;
    byte_one[pbs_pkg::ST_RDY_BIT] = st_reg.rdy;
    byte_one[pbs_pkg::ST_CMP_BIT] = st_reg.mismatch;
    byte_one[pbs_pkg::ST_CAP_MSB:pbs_pkg::ST_CAP_LSB] =
      pbs_pkg::CAP_CODE;
    byte_one[pbs_pkg::ST_GUARD_BIT] = sector_guard_i;
    byte_one[pbs_pkg::ST_PGSZ_BIT] = page_len_528_i;
    byte_two = pbs_pkg::BYTE_RST;
    byte_two[pbs_pkg::ST_RDY_BIT] = st_reg.rdy;
  end

  assign fresh_byte = st_reg.stat_idx[3] ? byte_two : byte_one;

  // The page field sits one bit higher in the 528-byte layout.
  assign page_sel = page_len_528_i
    ? st_reg.addr[pbs_pkg::PG528_LSB +: pbs_pkg::PAGE_W]
    : st_reg.addr[pbs_pkg::PG512_LSB +: pbs_pkg::PAGE_W];

  always_comb
  begin
    st_next          = st_reg;
    st_next.sck_prev = pins_q.sck;
    st_next.cs_prev  = pins_q.cs_b;
    st_next.req_vld  = 1'b0;

    if (pins_q.cs_b)
    begin
      // Deselect ends any frame at whatever bit it stood.
      st_next.phase   = pbs_pkg::PH_CMD;
      st_next.bit_cnt = 5'h00;
      st_next.so_oe   = 1'b0;
      st_next.armed   = 1'b0;
      // A page command launches only if idle; otherwise it is dropped.
      if (cs_rise && st_reg.armed && st_reg.seq == pbs_pkg::SQ_IDLE)
      begin
        st_next.req_vld      = 1'b1;
        st_next.req.page     = page_sel;
        st_next.req.op       = pbs_pkg::AOP_XFER;
        st_next.req.buf_sel  = 1'b0;
        case (st_reg.opcode)
          pbs_pkg::OP_XFER_B1, pbs_pkg::OP_XFER_B2:
          begin
            st_next.seq         = pbs_pkg::SQ_XFER;
            st_next.req.buf_sel = st_reg.opcode == pbs_pkg::OP_XFER_B2;
          end
          pbs_pkg::OP_COMP_B1, pbs_pkg::OP_COMP_B2:
          begin
            st_next.seq         = pbs_pkg::SQ_COMP;
            st_next.req.op      = pbs_pkg::AOP_COMPARE;
            st_next.req.buf_sel = st_reg.opcode[0];
          end
          default:
          begin
            st_next.seq         = pbs_pkg::SQ_RW_XFER;
            st_next.req.buf_sel = st_reg.opcode[0];
          end
        endcase
      end
    end
    else if (sck_rise)
    begin
      st_next.bit_cnt = st_reg.bit_cnt + 5'h01;
      case (st_reg.phase)
        pbs_pkg::PH_CMD:
        begin
          st_next.opcode = opc_full;
          if (st_reg.bit_cnt == pbs_pkg::OPC_LAST)
          begin
            st_next.bit_cnt = 5'h00;
            case (opc_full)
              pbs_pkg::OP_STATUS:
              begin
                // Accepted regardless of the sequencer state.
                st_next.phase    = pbs_pkg::PH_STATUS;
                st_next.stat_idx = pbs_pkg::STAT_IDX_RST;
              end
              pbs_pkg::OP_XFER_B1, pbs_pkg::OP_XFER_B2,
              pbs_pkg::OP_COMP_B1, pbs_pkg::OP_COMP_B2,
              pbs_pkg::OP_REWRITE_B1, pbs_pkg::OP_REWRITE_B2:
                st_next.phase = pbs_pkg::PH_ADDR;
              default:
                st_next.phase = pbs_pkg::PH_IGNORE;
            endcase
          end
        end
        pbs_pkg::PH_ADDR:
        begin
          st_next.addr = addr_full;
          if (st_reg.bit_cnt == pbs_pkg::ADDR_LAST)
          begin
            st_next.armed = 1'b1;
            st_next.phase = pbs_pkg::PH_IGNORE;
          end
        end
        default:
          st_next.bit_cnt = st_reg.bit_cnt;
      endcase
    end
    else if (sck_fall && st_reg.phase == pbs_pkg::PH_STATUS)
    begin
      st_next.so_oe    = 1'b1;
      st_next.stat_idx = st_reg.stat_idx + 4'h1;
      if (st_reg.stat_idx[2:0] == 3'h0)
      begin
        // Each byte is captured afresh at its first bit.
        st_next.stat_byte = {fresh_byte[6:0], 1'b0};
        st_next.so        = fresh_byte[7];
      end
      else
      begin
        st_next.stat_byte = {st_reg.stat_byte[6:0], 1'b0};
        st_next.so        = st_reg.stat_byte[7];
      end
    end

    // Sequencer steps on each done pulse from the array engine.
    if (arr_done_i)
    begin
      case (st_reg.seq)
        pbs_pkg::SQ_XFER:
          st_next.seq = pbs_pkg::SQ_IDLE;
        pbs_pkg::SQ_COMP:
        begin
          st_next.seq      = pbs_pkg::SQ_IDLE;
          st_next.mismatch = arr_mismatch_i;
        end
        pbs_pkg::SQ_RW_XFER:
        begin
          st_next.seq     = pbs_pkg::SQ_RW_PROG;
          st_next.req_vld = 1'b1;
          st_next.req.op  = pbs_pkg::AOP_PROGRAM;
        end
        pbs_pkg::SQ_RW_PROG:
          st_next.seq = pbs_pkg::SQ_IDLE;
        default:
          st_next.seq = st_reg.seq;
      endcase
    end

    st_next.rdy = st_next.seq == pbs_pkg::SQ_IDLE;
  end

  always_ff @(posedge mclk_i)
  begin
    if (!rst_b_i)
    begin
      st_reg <= '{
        sck_prev:  1'b0,
        cs_prev:   1'b1,
        phase:     pbs_pkg::PH_CMD,
        bit_cnt:   5'h00,
        opcode:    8'h00,
        addr:      24'h000000,
        armed:     1'b0,
        seq:       pbs_pkg::SQ_IDLE,
        mismatch:  1'b0,
        stat_idx:  pbs_pkg::STAT_IDX_RST,
        stat_byte: pbs_pkg::BYTE_RST,
        so:        1'b0,
        so_oe:     1'b0,
        rdy:       1'b1,
        req_vld:   1'b0,
        req:       '{op: pbs_pkg::AOP_XFER, buf_sel: 1'b0, page: 12'h000}
      };
    end
    else
    begin
      st_reg <= st_next;
    end
  end

  assign so_o          = st_reg.so;
  assign so_oe_o       = st_reg.so_oe;
  assign arr_req_vld_o = st_reg.req_vld;
  assign arr_req_o     = st_reg.req;
  assign ready_o       = st_reg.rdy;

  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (!rst_b_i);

  sequence s_launch;
    cs_rise && st_reg.armed && st_reg.seq == pbs_pkg::SQ_IDLE;
  endsequence

  sequence s_rw_first_done;
    st_reg.seq == pbs_pkg::SQ_RW_XFER && arr_done_i;
  endsequence

  a_launch_busy: assert property (
    s_launch |=> arr_req_vld_o && !ready_o)
    else $error("Launch did not raise a request and busy.");

  a_page_528: assert property (
    s_launch and page_len_528_i |=>
      arr_req_o.page == $past(st_reg.addr[21:10]))
    else $error("Page field wrong in 528-byte layout.");

  a_page_512: assert property (
    s_launch and !page_len_528_i |=>
      arr_req_o.page == $past(st_reg.addr[20:9]))
    else $error("Page field wrong in 512-byte layout.");

  a_rewrite_order: assert property (
    s_rw_first_done |=> arr_req_vld_o
      && arr_req_o.op == pbs_pkg::AOP_PROGRAM && !ready_o)
    else $error("Rewrite did not program after copying.");

  a_ready_done: assert property (
    arr_done_i && st_reg.seq inside {pbs_pkg::SQ_XFER, pbs_pkg::SQ_COMP,
      pbs_pkg::SQ_RW_PROG} |=> ready_o)
    else $error("Ready not shown after the last step.");

  a_comp_result: assert property (
    arr_done_i && st_reg.seq == pbs_pkg::SQ_COMP |=>
      st_reg.mismatch == $past(arr_mismatch_i))
    else $error("Compare result not captured.");

  a_oe_release: assert property (
    pins_q.cs_b |=> !so_oe_o [*2])
    else $error("Serial output not released on deselect.");

  a_status_rdy: assert property (
    sck_fall && st_reg.phase == pbs_pkg::PH_STATUS
      && st_reg.stat_idx[2:0] == 3'h0 && !pins_q.cs_b
      |=> so_o == $past(st_reg.rdy) && so_oe_o)
    else $error("Ready flag not sent at byte start.");

  a_status_wrap: assert property (
    sck_fall && st_reg.phase == pbs_pkg::PH_STATUS
      && st_reg.stat_idx == 4'hF && !pins_q.cs_b
      |=> st_reg.stat_idx == 4'h0)
    else $error("Status did not wrap to byte one.");

  a_status_busy: assert property (
    sck_rise && !pins_q.cs_b && st_reg.phase == pbs_pkg::PH_CMD
      && st_reg.bit_cnt == 5'h07 && opc_full == pbs_pkg::OP_STATUS
      |=> st_reg.phase == pbs_pkg::PH_STATUS)
    else $error("Status command refused.");

endmodule

// >>> sim/pbs_host.sv
// Serial host model for the page buffer and status read block.
// Assumes the core clock paces it; the serial clock is 8 core cycles long.
`timescale 1ns/10ps
module pbs_host (
  // Clock
  input  wire logic mclk_i,
  // Serial pins
  output logic      cs_b_o,
  output logic      sck_o,
  output logic      si_o,
  input  wire logic so_i
);
  initial
  begin
    cs_b_o = 1'b1;
    sck_o  = 1'b0;
    si_o   = 1'b0;
  end

  // The data line toggles while deselected so stale bits never look valid.
  always @(posedge mclk_i)
  begin
    if (cs_b_o)
      si_o <= ~si_o;
  end

  // Sends ntx bits MSB first, then reads nrx bits in the clock high phase.
  task automatic frame(input logic [31:0] tx, input int ntx,
                       input int nrx, output logic [31:0] rx);
    int i;
    rx = '0;
    @(posedge mclk_i);
    cs_b_o <= 1'b0;
    for (i = 0; i < ntx + nrx; i++)
    begin
      @(posedge mclk_i);
      if (i < ntx)
        si_o <= tx[31-i];
      repeat (3) @(posedge mclk_i);
      sck_o <= 1'b1;
      repeat (2) @(posedge mclk_i);
      if (i >= ntx)
        rx = {rx[30:0], so_i};
      repeat (2) @(posedge mclk_i);
      sck_o <= 1'b0;
    end
    repeat (4) @(posedge mclk_i);
    cs_b_o <= 1'b1;
    repeat (4) @(posedge mclk_i);
  endtask
endmodule

// >>> sim/test_page_buffer_ops_status_read.sv
// Self-checking bench for the page buffer and status read block.
// Assumes pbs_core as the device and pbs_host as the serial host.
`timescale 1ns/10ps
module test_page_buffer_ops_status_read;
  typedef struct packed {
    logic [7:0]        opc;
    logic              m528;
    logic [11:0]       page;
    pbs_pkg::pbs_aop_e op;
    logic              bsel;
  } pbs_row_s;

  logic                  mclk = 1'b0;
  logic                  rst_b = 1'b0;
  logic                  cs_b;
  logic                  sck;
  logic                  si;
  logic                  so;
  logic                  so_oe;
  logic                  so_line;
  logic                  guard = 1'b0;
  logic                  m528 = 1'b1;
  logic                  req_vld;
  pbs_pkg::pbs_arr_req_s req;
  logic                  done = 1'b0;
  logic                  mis = 1'b0;
  logic                  ready;
  pbs_pkg::pbs_arr_req_s req_q[$];
  int                    lat = 5;
  logic                  mis_cfg = 1'b0;
  int                    cnt = 0;
  int                    errors = 0;
  int                    checked = 0;
  logic [31:0]           rx;
  pbs_row_s              rows[6];

  always #20 mclk = ~mclk;

  pbs_core u_dut (.mclk_i(mclk), .rst_b_i(rst_b), .cs_b_i(cs_b),
    .sck_i(sck), .si_i(si), .so_o(so), .so_oe_o(so_oe),
    .sector_guard_i(guard), .page_len_528_i(m528),
    .arr_req_vld_o(req_vld), .arr_req_o(req), .arr_done_i(done),
    .arr_mismatch_i(mis), .ready_o(ready));

  pbs_host u_host (.mclk_i(mclk), .cs_b_o(cs_b), .sck_o(sck), .si_o(si),
    .so_i(so_line));

  // A released output shows the inverse of its last bit, so a read outside
  // the enabled window cannot pass by luck.
  assign so_line = so_oe ? so : ~so;

  // Array engine: answers each step with one done pulse after lat cycles.
  always @(posedge mclk)
  begin
    done <= 1'b0;
    if (req_vld === 1'b1)
    begin
      req_q.push_back(req);
      cnt <= lat;
    end
    else if (cnt > 0)
    begin
      cnt <= cnt - 1;
      if (cnt == 1)
      begin
        done <= 1'b1;
        mis  <= mis_cfg;
      end
    end
  end

  task automatic results;
    $display("checked %0d errors %0d", checked, errors);
    if (errors == 0 && checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] exp,
                     input logic [31:0] got);
    checked++;
    if (got !== exp)
    begin
      errors++;
      $display("mismatch %s expected %0h seen %0h", nm, exp, got);
    end
  endtask

  task automatic cmd(input logic [7:0] opc, input logic [11:0] pg,
                     input logic md);
    logic [23:0] a;
    a = md ? {2'b11, pg, 10'h3FF} : {3'b111, pg, 9'h1FF};
    u_host.frame({opc, a}, 32, 0, rx);
  endtask

  task automatic stat(input int n);
    u_host.frame({pbs_pkg::OP_STATUS, 24'h000000}, 8, n, rx);
  endtask

  task automatic wait_rdy;
    int i;
    for (i = 0; i < 3000 && ready !== 1'b1; i++)
      @(posedge mclk);
    chk("ready wait", 1, ready);
  endtask

  initial
  begin
    repeat (40000) @(posedge mclk);
    errors++;
    results();
  end

  initial
  begin
    rows[0] = {pbs_pkg::OP_XFER_B1, 1'b1, 12'hA5C, pbs_pkg::AOP_XFER, 1'b0};
    rows[1] = {pbs_pkg::OP_XFER_B2, 1'b0, 12'h3A1, pbs_pkg::AOP_XFER, 1'b1};
    rows[2] = {pbs_pkg::OP_COMP_B1, 1'b1, 12'hFFF, pbs_pkg::AOP_COMPARE,
               1'b0};
    rows[3] = {pbs_pkg::OP_COMP_B2, 1'b0, 12'h001, pbs_pkg::AOP_COMPARE,
               1'b1};
    rows[4] = {pbs_pkg::OP_REWRITE_B1, 1'b1, 12'h5A5, pbs_pkg::AOP_PROGRAM,
               1'b0};
    rows[5] = {pbs_pkg::OP_REWRITE_B2, 1'b0, 12'hC3C, pbs_pkg::AOP_PROGRAM,
               1'b1};
    repeat (10) @(posedge mclk);
    rst_b <= 1'b1;
    repeat (4) @(posedge mclk);
    chk("reset ready", 1, ready);
    chk("reset so_oe", 0, so_oe);
    chk("reset req", 0, req_vld);
    foreach (rows[k])
    begin
      m528 <= rows[k].m528;
      lat = 250;
      req_q.delete();
      cmd(rows[k].opc, rows[k].page, rows[k].m528);
      chk("busy", 0, ready);
      stat(16);
      chk("busy bits", 0, {rx[15], rx[7]});
      wait_rdy();
      chk("steps", (rows[k].op == pbs_pkg::AOP_PROGRAM) ? 2 : 1,
          req_q.size());
      foreach (req_q[j])
      begin
        chk("op", (j == 0 && req_q.size() == 2) ? pbs_pkg::AOP_XFER :
            rows[k].op, req_q[j].op);
        chk("buf", rows[k].bsel, req_q[j].buf_sel);
        chk("page", rows[k].page, req_q[j].page);
      end
    end
    // Compare mismatch; ready is resampled as the read wraps past done.
    guard <= 1'b1;
    m528 <= 1'b0;
    mis_cfg = 1'b1;
    lat = 150;
    cmd(pbs_pkg::OP_COMP_B1, 12'h123, 1'b0);
    stat(24);
    chk("ready per byte", 3'b001, {rx[23], rx[15], rx[7]});
    wait_rdy();
    stat(24);
    chk("status wrap", {1'b1, 1'b1, pbs_pkg::CAP_CODE, 2'b10, 8'h80,
        1'b1, 1'b1, pbs_pkg::CAP_CODE, 2'b10}, rx);
    guard <= 1'b0;
    m528 <= 1'b1;
    mis_cfg = 1'b0;
    lat = 5;
    cmd(pbs_pkg::OP_COMP_B2, 12'h321, 1'b1);
    wait_rdy();
    stat(16);
    chk("status match", {8'h95, 8'h80}, rx);
    // Deselect in mid-byte releases the output.
    stat(3);
    chk("so_oe off", 0, so_oe);
    // Short, unknown and busy-time page commands launch nothing more.
    req_q.delete();
    u_host.frame({pbs_pkg::OP_XFER_B1, 24'h000000}, 31, 0, rx);
    cmd(8'h00, 12'h010, 1'b1);
    repeat (8) @(posedge mclk);
    chk("dropped", 0, req_q.size());
    lat = 300;
    cmd(pbs_pkg::OP_COMP_B1, 12'h010, 1'b1);
    cmd(pbs_pkg::OP_XFER_B2, 12'h020, 1'b1);
    wait_rdy();
    chk("busy drop", 1, req_q.size());
    results();
  end
endmodule
